//--- rtl/asf_pkg.sv
// Overview of operation
// RULE1 - Flag writes ignored for five flags when instruction updates them from ALU.
// RULE2 - File clear of flag register sets zero flag, others unchanged.
// RULE3 - Software should alter flags only with set, clear, swap or move ops.
// RULE4 - Upper three bits unimplemented, read zero, writes ignored.
// RULE5 - Negative flag copies result bit seven.
// RULE6 - Signed wrap flag set when signed result overflows seven-bit magnitude.
// RULE7 - Zero flag set when result is zero, cleared otherwise.
// RULE8 - Nibble carry flag is carry out of bit three for add and subtract.
// RULE9 - Carry flag is carry out of bit seven for add and subtract.
// RULE10 - Subtract adds two's complement, so carries act as inverted borrows.
// RULE11 - Flag register usable as ordinary operand of any instruction.
// RULE12 - Flag register sits at access bank address fd8.
// RULE13 - Inherent, literal, direct, indirect modes; indexed only with extended bit set.
// RULE14 - Flags an instruction does not affect keep their stored value.
package asf_pkg;
  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam logic [11:0] ASF_FLAGS_ADDR = 12'hfd8;
  localparam int ASF_BIT_C = 0;
  localparam int ASF_BIT_DC = 1;
  localparam int ASF_BIT_Z = 2;
  localparam int ASF_BIT_OV = 3;
  localparam int ASF_BIT_N = 4;
  localparam logic [7:0] ASF_IMPL_MASK = 8'h1f;
  localparam logic [4:0] ASF_FLAGS_RESET = 5'h00;

  // ****************************************
  // Operations
  // ****************************************
  typedef enum logic [3:0] {
    ASF_OP_NONE = 4'h0,
    ASF_OP_ADD = 4'h1,
    ASF_OP_SUB = 4'h2,
    ASF_OP_AND = 4'h3,
    ASF_OP_OR = 4'h4,
    ASF_OP_XOR = 4'h5,
    ASF_OP_CLR = 4'h6,
    ASF_OP_MOV = 4'h7,
    ASF_OP_BSET = 4'h8,
    ASF_OP_BCLR = 4'h9,
    ASF_OP_SWAP = 4'ha
  } asf_op_t;

  typedef enum logic [4:0] {
    ASF_AM_INHERENT = 5'h01,
    ASF_AM_LITERAL = 5'h02,
    ASF_AM_DIRECT = 5'h04,
    ASF_AM_INDIRECT = 5'h08,
    ASF_AM_INDEXED = 5'h10
  } asf_amode_t;
endpackage : asf_pkg

//--- rtl/asf_adder.sv
`timescale 1ns/1ps
`default_nettype none
module asf_adder (
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic sub,
  // Result
  output logic [7:0] sum,
  output logic c_out,
  output logic dc_out,
  output logic ov_out
);
  logic [7:0] b_eff;
  logic [8:0] full;
  logic [4:0] low;
  // Subtract adds the two's complement of b, so carry reads as not-borrow
  assign b_eff = sub ? ~b : b; // [RULE10]
  assign full = {1'b0, a} + {1'b0, b_eff} + {8'h00, sub};
  assign low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub};
  assign sum = full[7:0];
  assign c_out = full[8]; // [RULE9]
  assign dc_out = low[4]; // [RULE8]
  assign ov_out = (a[7] == b_eff[7]) && (sum[7] != a[7]); // [RULE6]
endmodule : asf_adder
`default_nettype wire

//--- rtl/asf_amode.sv
`timescale 1ns/1ps
`default_nettype none
module asf_amode
  import asf_pkg::*;
(
  // Mode request
  input wire asf_pkg::asf_amode_t amode,
  input wire logic extended_isa_config_bit,
  // Verdict
  output logic amode_ok
);
  always_comb begin
    unique case (amode)
      ASF_AM_INHERENT, ASF_AM_LITERAL, ASF_AM_DIRECT, ASF_AM_INDIRECT: amode_ok = 1'b1;
      ASF_AM_INDEXED: amode_ok = extended_isa_config_bit; // [RULE13]
      default: amode_ok = 1'b0;
    endcase
  end
endmodule : asf_amode
`default_nettype wire

//--- rtl/alu_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module alu_status_flags
  import asf_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Instruction execution
  input wire logic op_valid,
  input wire asf_pkg::asf_op_t op,
  input wire asf_pkg::asf_amode_t amode,
  input wire logic extended_isa_config_bit,
  input wire logic [11:0] dst_addr,
  input wire logic dst_file,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic [2:0] bit_sel,
  // Result
  output logic [7:0] result,
  output logic result_valid,
  output logic amode_err,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import asf_pkg::*;

  // ****************************************
  // Datapath
  // ****************************************
  logic [4:0] flags;
  logic [4:0] next_flags;
  logic [7:0] add_sum;
  logic add_c;
  logic add_dc;
  logic add_ov;
  logic amode_ok;
  logic [7:0] alu_out;
  logic arith;
  logic logic_op;
  logic to_flags;
  logic [7:0] flags_byte;

  asf_adder u_adder (
    .a(opa),
    .b(opb),
    .sub(op == ASF_OP_SUB),
    .sum(add_sum),
    .c_out(add_c),
    .dc_out(add_dc),
    .ov_out(add_ov)
  );

  asf_amode u_amode (
    .amode(amode),
    .extended_isa_config_bit(extended_isa_config_bit),
    .amode_ok(amode_ok)
  );

  assign flags_byte = {3'h0, flags}; // [RULE4]
  assign arith = (op == ASF_OP_ADD) || (op == ASF_OP_SUB);
  assign logic_op = (op == ASF_OP_AND) || (op == ASF_OP_OR) || (op == ASF_OP_XOR)
                    || (op == ASF_OP_CLR);
  // Flag register can be a destination like any file register
  assign to_flags = dst_file && (dst_addr == ASF_FLAGS_ADDR); // [RULE11] [RULE12]

  always_comb begin
    unique case (op)
      ASF_OP_ADD, ASF_OP_SUB: alu_out = add_sum;
      ASF_OP_AND: alu_out = opa & opb;
      ASF_OP_OR: alu_out = opa | opb;
      ASF_OP_XOR: alu_out = opa ^ opb;
      ASF_OP_CLR: alu_out = 8'h00;
      ASF_OP_MOV: alu_out = opa;
      ASF_OP_BSET: alu_out = opa | (8'h01 << bit_sel);
      ASF_OP_BCLR: alu_out = opa & ~(8'h01 << bit_sel);
      ASF_OP_SWAP: alu_out = {opa[3:0], opa[7:4]};
      default: alu_out = 8'h00;
    endcase
  end

  // ****************************************
  // Flag update
  // ****************************************
  always_comb begin
    next_flags = flags; // [RULE14]
    if (op_valid && amode_ok) begin
      // Direct write only for ops that set no flags; flag-producing ops update their own bits instead
      if (to_flags && !(arith || logic_op)) begin
        next_flags = alu_out[4:0]; // [RULE3] [RULE4]
      end
      if (arith || logic_op) begin
        // Write of the result to the flag register is discarded here [RULE1] [RULE2]
        next_flags[ASF_BIT_Z] = (alu_out == 8'h00); // [RULE7]
        // File clear sets only the zero flag; the negative flag keeps its value
        if (op != ASF_OP_CLR) begin // [RULE2]
          next_flags[ASF_BIT_N] = alu_out[7]; // [RULE5]
        end
      end
      if (arith) begin
        next_flags[ASF_BIT_C] = add_c; // [RULE9]
        next_flags[ASF_BIT_DC] = add_dc; // [RULE8]
        next_flags[ASF_BIT_OV] = add_ov; // [RULE6]
      end
    end else if (reg_wr && reg_addr == ASF_FLAGS_ADDR) begin
      next_flags = reg_wdata[4:0]; // [RULE4]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flags <= ASF_FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // ****************************************
  // Result and register read
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      result <= 8'h00;
      result_valid <= 1'b0;
      amode_err <= 1'b0;
    end else begin
      result_valid <= op_valid && amode_ok;
      amode_err <= op_valid && !amode_ok; // [RULE13]
      if (op_valid && amode_ok) begin
        result <= alu_out;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= (reg_addr == ASF_FLAGS_ADDR) ? flags_byte : 8'h00;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : alu_status_flags
`default_nettype wire

//--- testbench/asf_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module asf_chk
  import asf_pkg::*;
(
  // Watched ports
  input wire logic mclk,
  input wire logic nrst,
  input wire logic op_valid,
  input wire asf_pkg::asf_op_t op,
  input wire asf_pkg::asf_amode_t amode,
  input wire logic extended_isa_config_bit,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic [7:0] result,
  input wire logic result_valid,
  input wire logic amode_err,
  input wire logic [11:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire dir = op_valid && amode == ASF_AM_DIRECT;
  wire idx = op_valid && amode == ASF_AM_INDEXED;
  a_upper_zero: assert property (reg_rdata[7:5] == 3'h0)
    else $error("upper flag bits read nonzero");
  a_rdata_quiet: assert property (!(reg_rd && reg_addr == ASF_FLAGS_ADDR) |=> reg_rdata == 8'h00)
    else $error("read data outside a flag read");
  a_add_sum: assert property (dir && op == ASF_OP_ADD |=> result_valid && result == 8'($past(opa) + $past(opb)))
    else $error("add result wrong");
  a_sub_diff: assert property (dir && op == ASF_OP_SUB |=> result == 8'($past(opa) - $past(opb)))
    else $error("sub result wrong");
  a_index_refuse: assert property (idx && !extended_isa_config_bit |=> amode_err && !result_valid)
    else $error("indexed mode not refused");
  a_index_ok: assert property (idx && extended_isa_config_bit |=> !amode_err)
    else $error("indexed mode refused");
  a_idle_quiet: assert property (!op_valid |=> !result_valid && !amode_err)
    else $error("pulse without an op");
  a_result_hold: assert property (!result_valid |-> $stable(result))
    else $error("result moved without an op");
  c_sub: cover property (dir && op == ASF_OP_SUB);
  c_err: cover property (amode_err);
  c_read: cover property (reg_rd && reg_addr == ASF_FLAGS_ADDR);
endmodule : asf_chk
bind alu_status_flags asf_chk i_chk (.mclk, .nrst, .op_valid, .op, .amode,
  .extended_isa_config_bit, .opa, .opb, .result, .result_valid, .amode_err,
  .reg_addr, .reg_rd, .reg_rdata);
`default_nettype wire

//--- testbench/asf_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module asf_core_model
  import asf_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Instruction issue
  output logic op_valid,
  output asf_pkg::asf_op_t op,
  output asf_pkg::asf_amode_t amode,
  output logic extended_isa_config_bit,
  output logic [11:0] dst_addr,
  output logic dst_file,
  output logic [7:0] opa,
  output logic [7:0] opb,
  output logic [2:0] bit_sel
);
  initial begin
    op_valid = 1'b0;
    op = ASF_OP_NONE;
    amode = ASF_AM_DIRECT;
    extended_isa_config_bit = 1'b0;
    dst_addr = ASF_FLAGS_ADDR;
    dst_file = 1'b0;
    opa = 8'h00;
    opb = 8'h00;
    bit_sel = 3'h0;
  end
  // One-cycle issue; software normally alters flags only by moves, swaps and bit set or clear ops
  task automatic issue(input asf_op_t o, input asf_amode_t m, input logic x, input logic f,
      input logic [7:0] a, input logic [7:0] b);
    @(posedge mclk);
    op_valid <= 1'b1;
    op <= o;
    amode <= m;
    extended_isa_config_bit <= x;
    dst_file <= f;
    opa <= a;
    opb <= b;
    // Bit ops take their bit number from the low bits of the second operand
    bit_sel <= b[2:0];
    @(posedge mclk);
    op_valid <= 1'b0;
  endtask : issue
endmodule : asf_core_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asf_pkg::*;
  logic mclk, nrst, op_valid, extended_isa_config_bit, dst_file, result_valid, amode_err;
  logic reg_wr, reg_rd;
  asf_op_t op;
  asf_amode_t amode;
  logic [11:0] dst_addr, reg_addr;
  logic [7:0] opa, opb, result, reg_wdata, reg_rdata;
  logic [2:0] bit_sel;
  int err_total, tests_run;
  asf_core_model i_core (.mclk, .op_valid, .op, .amode, .extended_isa_config_bit, .dst_addr,
    .dst_file, .opa, .opb, .bit_sel);
  alu_status_flags i_dut (.mclk, .nrst, .op_valid, .op, .amode, .extended_isa_config_bit,
    .dst_addr, .dst_file, .opa, .opb, .bit_sel, .result, .result_valid, .amode_err,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic run(input asf_op_t o, input logic f, input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] r, input logic [7:0] fl);
    i_core.issue(o, ASF_AM_DIRECT, 1'b0, f, a, b);
    #1 chk(result, r);
    rd(ASF_FLAGS_ADDR, fl);
  endtask : run
  task automatic results();
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    rd(ASF_FLAGS_ADDR, 8'h00);
    wr(ASF_FLAGS_ADDR, 8'hff);
    rd(ASF_FLAGS_ADDR, 8'h1f);
    rd(12'h000, 8'h00);
    run(ASF_OP_ADD, 1'b0, 8'h7f, 8'h01, 8'h80, 8'h1a);
    run(ASF_OP_ADD, 1'b1, 8'hff, 8'h01, 8'h00, 8'h07);
    run(ASF_OP_SUB, 1'b0, 8'h05, 8'h06, 8'hff, 8'h10);
    run(ASF_OP_SUB, 1'b0, 8'h06, 8'h06, 8'h00, 8'h07);
    wr(ASF_FLAGS_ADDR, 8'h1b);
    run(ASF_OP_CLR, 1'b1, 8'h55, 8'h00, 8'h00, 8'h1f);
    run(ASF_OP_AND, 1'b0, 8'hf0, 8'h0f, 8'h00, 8'h0f);
    run(ASF_OP_SWAP, 1'b1, 8'h3c, 8'h00, 8'hc3, 8'h03);
    run(ASF_OP_BSET, 1'b1, 8'h03, 8'h04, 8'h13, 8'h13);
    run(ASF_OP_BCLR, 1'b1, 8'h13, 8'h00, 8'h12, 8'h12);
    run(ASF_OP_MOV, 1'b0, 8'h80, 8'h00, 8'h80, 8'h12);
    run(ASF_OP_XOR, 1'b0, 8'h5a, 8'h5a, 8'h00, 8'h06);
    run(ASF_OP_OR, 1'b0, 8'h80, 8'h01, 8'h81, 8'h12);
    for (int k = 0; k < 10; k++) begin
      i_core.issue(ASF_OP_ADD, asf_amode_t'(5'h01 << (k % 5)), k > 4, 1'b0, 8'h01, 8'h01);
      #1 chk({7'h00, amode_err}, {7'h00, k == 4});
    end
    results();
  end
  initial begin
    #20000;
    err_total++;
    results();
  end
endmodule : tb_top
`default_nettype wire
